// *** vc_arbitration_capability_regs.sv ***
// VC arbitration capability register bank behind an APB slave
//
// The APB register port was decided locally.
`timescale 1ns/1ps

//
// Contract
// - VC scheme bits 0..3, bits 7:4 reserved
// - VC scheme field only with low ext VCs
// - Table location in 31:24, 16-byte units
// - Table location always reads zero
// - Load table bit reads zero, no effect
// - Scheme select 3:1 writable, no effect
// - Table status bit always reads zero
// - Port arb reads 0x3 upstream, 0x1 downstream
// - Port arb bits 0..5 name the schemes
// - Several port arb bits set together on an upstream port only
// - Advanced packet switching bit reads zero
// - Reject snoop bit reads zero
module vc_arbitration_capability_regs #(
  parameter logic [2:0] LP_EXT_VC_COUNT = 3'h0,
  parameter logic [7:0] VC_ARB_SUPPORT  = 8'h00
) (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [13:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Port role strap pin and state, scheme select
  input  wire logic        upstream_port_pin,
  output logic             upstream_port,
  output logic      [2:0]  vc_arb_scheme_select
);

  // ----------------------------------------
  // Decode helpers
  // ----------------------------------------
  function automatic logic is_mapped(input logic [13:0] a);
    return a == vc_arb_cap_pkg::CAP_TWO_ADDR ||
           a == vc_arb_cap_pkg::CTL_ADDR ||
           a == vc_arb_cap_pkg::STS_ADDR ||
           a == vc_arb_cap_pkg::RES0_ADDR;
  endfunction

  function automatic logic [7:0] port_arb(input logic up);
    return up ? vc_arb_cap_pkg::PORT_ARB_UP
              : vc_arb_cap_pkg::PORT_ARB_DOWN;
  endfunction

  // ----------------------------------------
  // Strap synchroniser
  // ----------------------------------------
  logic up_meta_q;
  logic up_meta_d;
  logic up_sync_q;
  logic up_sync_d;

  always_comb
  begin
    up_meta_d = upstream_port_pin;
    up_sync_d = up_meta_q;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      up_meta_q <= 1'b0;
      up_sync_q <= 1'b0;
    end
    else
    begin
      up_meta_q <= up_meta_d;
      up_sync_q <= up_sync_d;
    end
  end

  assign upstream_port = up_sync_q;

  // ----------------------------------------
  // Fixed register images
  // ----------------------------------------
  logic [7:0]  scheme_support;
  logic [31:0] cap_two_word;
  logic [31:0] res0_word;

  always_comb
  begin
    // Reserved scheme bits are masked so a bad default cannot leak
    scheme_support = 8'h00;
    if (LP_EXT_VC_COUNT != 3'h0)
    begin
      scheme_support[vc_arb_cap_pkg::SCHEME_USED:0] =
        VC_ARB_SUPPORT[vc_arb_cap_pkg::SCHEME_USED:0];
    end
    cap_two_word = vc_arb_cap_pkg::WORD_ZERO;
    cap_two_word[vc_arb_cap_pkg::SCHEME_MSB:0] = scheme_support;
    cap_two_word[31:vc_arb_cap_pkg::TBL_LOC_LSB] =
      vc_arb_cap_pkg::TBL_LOC_VAL;
    res0_word = vc_arb_cap_pkg::WORD_ZERO;
    res0_word[7:0] = port_arb(up_sync_q);
    res0_word[vc_arb_cap_pkg::PKT_SWITCH_BIT] = 1'b0;
    res0_word[vc_arb_cap_pkg::SNOOP_REJECT_BIT] = 1'b0;
  end

  // ----------------------------------------
  // Writable scheme select
  // ----------------------------------------
  logic [2:0] sel_q;
  logic [2:0] sel_d;
  logic       wr_access;

  assign wr_access = psel && penable && pwrite;

  always_comb
  begin
    // Only bits 3:1 take writes; bit 0 and 15:4 drop them
    sel_d = sel_q;
    if (wr_access && paddr == vc_arb_cap_pkg::CTL_ADDR && pstrb[0])
    begin
      sel_d = pwdata[vc_arb_cap_pkg::SEL_MSB:vc_arb_cap_pkg::SEL_LSB];
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sel_q <= vc_arb_cap_pkg::SEL_RESET;
    end
    else
    begin
      sel_q <= sel_d;
    end
  end

  // Select is reported but steers nothing: only the default VC exists
  assign vc_arb_scheme_select = sel_q;

  // ----------------------------------------
  // Read data and error, loaded in setup
  // ----------------------------------------
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic        err_q;
  logic        err_d;
  logic        setup;

  assign setup = psel && !penable;

  always_comb
  begin
    rdata_d = rdata_q;
    err_d   = err_q;
    if (setup)
    begin
      err_d   = !is_mapped(paddr);
      rdata_d = vc_arb_cap_pkg::WORD_ZERO;
      if (!pwrite)
      begin
        case (paddr)
          vc_arb_cap_pkg::CAP_TWO_ADDR: rdata_d = cap_two_word;
          vc_arb_cap_pkg::CTL_ADDR:
          begin
            rdata_d[vc_arb_cap_pkg::SEL_MSB:vc_arb_cap_pkg::SEL_LSB] =
              sel_q;
            rdata_d[vc_arb_cap_pkg::LOAD_BIT] = 1'b0;
          end
          vc_arb_cap_pkg::STS_ADDR:
            rdata_d[vc_arb_cap_pkg::TBL_STS_BIT] = 1'b0;
          vc_arb_cap_pkg::RES0_ADDR: rdata_d = res0_word;
          default: rdata_d = vc_arb_cap_pkg::WORD_ZERO;
        endcase
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rdata_q <= vc_arb_cap_pkg::WORD_ZERO;
      err_q   <= 1'b0;
    end
    else
    begin
      rdata_q <= rdata_d;
      err_q   <= err_d;
    end
  end

  // Zero wait states: every access completes in its first access cycle
  assign pready  = 1'b1;
  assign prdata  = rdata_q;
  assign pslverr = err_q && psel && penable;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  logic rd_acc;
  assign rd_acc = psel && penable && !pwrite;

  property p_scheme_reserved;
    rd_acc && paddr == vc_arb_cap_pkg::CAP_TWO_ADDR |->
      prdata[7:4] == 4'h0;
  endproperty
  a_scheme_reserved: assert property (p_scheme_reserved)
    else $error("Reserved VC scheme bits read nonzero");

  property p_scheme_gated;
    rd_acc && paddr == vc_arb_cap_pkg::CAP_TWO_ADDR &&
      LP_EXT_VC_COUNT == 3'h0 |-> prdata[7:0] == 8'h00;
  endproperty
  a_scheme_gated: assert property (p_scheme_gated)
    else $error("VC scheme field set with no low ext VCs");

  property p_tbl_loc;
    rd_acc && paddr == vc_arb_cap_pkg::CAP_TWO_ADDR |->
      prdata[31:8] == 24'h000000;
  endproperty
  a_tbl_loc: assert property (p_tbl_loc)
    else $error("Table location or reserved bits nonzero");

  property p_ctl_read;
    rd_acc && paddr == vc_arb_cap_pkg::CTL_ADDR |->
      prdata == {28'h0000000, sel_q, 1'b0};
  endproperty
  a_ctl_read: assert property (p_ctl_read)
    else $error("Control read wrong or load bit set");

  property p_sel_write;
    wr_access && paddr == vc_arb_cap_pkg::CTL_ADDR && pstrb[0] |=>
      vc_arb_scheme_select == $past(pwdata[3:1]);
  endproperty
  a_sel_write: assert property (p_sel_write)
    else $error("Scheme select did not take the write");

  property p_sel_stable;
    !(wr_access && paddr == vc_arb_cap_pkg::CTL_ADDR) |=>
      $stable(vc_arb_scheme_select);
  endproperty
  a_sel_stable: assert property (p_sel_stable)
    else $error("Scheme select changed without a write");

  property p_sts_zero;
    rd_acc && paddr == vc_arb_cap_pkg::STS_ADDR |->
      prdata == 32'h0000_0000;
  endproperty
  a_sts_zero: assert property (p_sts_zero)
    else $error("Table status read nonzero");

  property p_port_arb;
    rd_acc && paddr == vc_arb_cap_pkg::RES0_ADDR |->
      prdata[7:0] == (upstream_port ? 8'h03 : 8'h01);
  endproperty
  a_port_arb: assert property (p_port_arb)
    else $error("Port arbitration field wrong for port role");

  property p_res0_high;
    rd_acc && paddr == vc_arb_cap_pkg::RES0_ADDR |->
      prdata[31:8] == 24'h000000;
  endproperty
  a_res0_high: assert property (p_res0_high)
    else $error("Packet switching or snoop bit set");

  property p_unmapped;
    psel && !penable && !is_mapped(paddr) ##1 psel && penable |->
      pslverr && prdata == 32'h0000_0000;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("Unmapped access not flagged");

  property p_snoop_zero;
    rd_acc && paddr == vc_arb_cap_pkg::RES0_ADDR |->
      prdata[vc_arb_cap_pkg::SNOOP_REJECT_BIT] == 1'b0;
  endproperty
  a_snoop_zero: assert property (p_snoop_zero)
    else $error("Reject snoop bit set");

  property p_port_arb_multi;
    rd_acc && paddr == vc_arb_cap_pkg::RES0_ADDR && upstream_port |->
      $countones(prdata[7:0]) > 1;
  endproperty
  a_port_arb_multi: assert property (p_port_arb_multi)
    else $error("Upstream port advertises a single scheme");

  sequence sel_write_seq;
    wr_access && paddr == vc_arb_cap_pkg::CTL_ADDR ##1 sel_q != 3'h0;
  endsequence
  c_sel_write: cover property (sel_write_seq);
  c_up_read: cover property (rd_acc && upstream_port &&
    paddr == vc_arb_cap_pkg::RES0_ADDR);
  c_err: cover property (pslverr);

endmodule

// *** vc_arb_cap_pkg.sv ***
// Constants for the VC arbitration capability register bank
package vc_arb_cap_pkg;

  // ----------------------------------------
  // Register indexes and byte addresses
  // ----------------------------------------
  localparam logic [11:0] CAP_TWO_IDX = 12'h208;
  localparam logic [11:0] CTL_IDX     = 12'h20c;
  localparam logic [11:0] STS_IDX     = 12'h20e;
  localparam logic [11:0] RES0_IDX    = 12'h210;
  localparam logic [13:0] CAP_TWO_ADDR = {CAP_TWO_IDX, 2'b00};
  localparam logic [13:0] CTL_ADDR     = {CTL_IDX, 2'b00};
  localparam logic [13:0] STS_ADDR     = {STS_IDX, 2'b00};
  localparam logic [13:0] RES0_ADDR    = {RES0_IDX, 2'b00};

  // ----------------------------------------
  // Field positions and fixed values
  // ----------------------------------------
  localparam int SCHEME_MSB   = 7;
  localparam int SCHEME_USED  = 3;
  localparam int TBL_LOC_LSB  = 24;
  localparam int SEL_LSB      = 1;
  localparam int SEL_MSB      = 3;
  localparam int LOAD_BIT     = 0;
  localparam int TBL_STS_BIT  = 0;
  localparam int PKT_SWITCH_BIT   = 14;
  localparam int SNOOP_REJECT_BIT = 15;
  localparam logic [7:0] TBL_LOC_VAL   = 8'h00;
  localparam logic [7:0] PORT_ARB_UP   = 8'h03;
  localparam logic [7:0] PORT_ARB_DOWN = 8'h01;
  localparam logic [2:0] SEL_RESET     = 3'h0;
  localparam logic [31:0] WORD_ZERO    = 32'h0000_0000;

endpackage

// *** vc_arbitration_capability_regs_tb_top.sv ***
// Self-checking testbench for the VC arbitration capability registers
`timescale 1ns/1ps

module vc_arbitration_capability_regs_tb_top;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [13:0] paddr;
  logic [31:0] pwdata;
  logic [3:0]  pstrb;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [31:0] prdata_nx;
  logic        upstream_port_pin;
  logic        upstream_port;
  logic [2:0]  vc_arb_scheme_select;
  logic [33:0] notes[$];
  logic [2:0]  sel_m;
  logic        role;
  int          n_mismatch;
  int          cmp_count;

  vc_arbitration_capability_regs #(
    .LP_EXT_VC_COUNT(3'h1),
    .VC_ARB_SUPPORT (8'hff)
  ) vc_arbitration_capability_regs_inst (
    .pclk                (pclk),
    .presetn             (presetn),
    .psel                (psel),
    .penable             (penable),
    .pwrite              (pwrite),
    .paddr               (paddr),
    .pwdata              (pwdata),
    .pstrb               (pstrb),
    .prdata              (prdata),
    .pready              (pready),
    .pslverr             (pslverr),
    .upstream_port_pin   (upstream_port_pin),
    .upstream_port       (upstream_port),
    .vc_arb_scheme_select(vc_arb_scheme_select)
  );

  // Default build: no low priority ext VCs, so the scheme field is hidden
  vc_arbitration_capability_regs vc_arbitration_capability_regs_no_ext_inst (
    .pclk                (pclk),
    .presetn             (presetn),
    .psel                (psel),
    .penable             (penable),
    .pwrite              (pwrite),
    .paddr               (paddr),
    .pwdata              (pwdata),
    .pstrb               (pstrb),
    .prdata              (prdata_nx),
    .pready              (),
    .pslverr             (),
    .upstream_port_pin   (upstream_port_pin),
    .upstream_port       (),
    .vc_arb_scheme_select()
  );

  always #10 pclk = ~pclk;

  // ----------------------------------------
  // Compare and closing
  // ----------------------------------------
  task automatic check(input string nm, input logic [31:0] e, g);
    cmp_count++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wrap_up;
    if (n_mismatch == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // ----------------------------------------
  // APB master; note is {is_read, err, data}
  // ----------------------------------------
  // Leaves psel high so the next setup can follow at once
  task automatic apb(input logic w, input logic [13:0] a,
                     input logic [31:0] d, input logic [3:0] s,
                     input logic [33:0] n);
    int i;
    notes.push_back(n);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    pstrb   <= s;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 16; i++)
    begin
      @(posedge pclk);
      if (pready === 1'b1)
        break;
    end
    if (i == 16)
    begin
      n_mismatch++;
      wrap_up();
    end
  endtask

  task automatic idle;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic rd(input logic [13:0] a, input logic [31:0] e);
    apb(1'b0, a, $urandom, 4'hf, {2'b10, e});
  endtask

  // Writes with pstrb[0] low must leave every register as it was
  task automatic check_all;
    logic [13:0] ad[4];
    logic [31:0] ex[4];
    ad = '{vc_arb_cap_pkg::CAP_TWO_ADDR, vc_arb_cap_pkg::CTL_ADDR,
           vc_arb_cap_pkg::STS_ADDR, vc_arb_cap_pkg::RES0_ADDR};
    ex = '{32'h0000_000f, {28'h0, sel_m, 1'b0}, 32'h0,
           role ? 32'h0000_0003 : 32'h0000_0001};
    for (int k = 0; k < 4; k++)
    begin
      rd(ad[k], ex[k]);
      apb(1'b1, ad[k], $urandom, 4'he, 34'h0);
      rd(ad[k], ex[k]);
    end
    idle();
  endtask

  // ----------------------------------------
  // Monitor: oldest note against each finished transfer
  // ----------------------------------------
  always @(posedge pclk)
  begin
    logic [33:0] n;
    if (presetn && psel && penable && pready === 1'b1)
    begin
      n = (notes.size() > 0) ? notes.pop_front() : 34'h1_0000_dead;
      check("pslverr", {31'h0, n[32]}, {31'h0, pslverr});
      if (n[33])
        check("prdata", n[31:0], prdata);
      if (n[33] && paddr == vc_arb_cap_pkg::CAP_TWO_ADDR)
        check("prdata_no_ext", 32'h0, prdata_nx);
    end
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    logic [31:0] d;
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 14'h0;
    pwdata = 32'h0;
    pstrb = 4'h0;
    upstream_port_pin = 1'b0;
    n_mismatch = 0;
    cmp_count = 0;
    sel_m = 3'h0;
    role = 1'b0;
    d = $urandom(32'hbf90);
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
    check_all();
    // Every select value, load bit set each time, back to back
    for (int i = 0; i < 8; i++)
    begin
      d = ($urandom & 32'hffff_fff0) | {28'h0, i[2:0], 1'b1};
      apb(1'b1, vc_arb_cap_pkg::CTL_ADDR, d, 4'hf, 34'h0);
      rd(vc_arb_cap_pkg::CTL_ADDR, {28'h0, i[2:0], 1'b0});
      idle();
      check("select", {29'h0, i[2:0]}, {29'h0, vc_arb_scheme_select});
    end
    sel_m = 3'h7;
    check_all();
    // Unmapped place: error, zero data, no write lands
    apb(1'b1, 14'h0824, 32'hffff_ffff, 4'hf, {2'b01, 32'h0});
    rd(vc_arb_cap_pkg::CTL_ADDR, 32'h0000_000e);
    apb(1'b0, 14'h0824, 32'h0, 4'hf, {2'b11, 32'h0});
    idle();
    // Upstream role: two schemes advertised together
    upstream_port_pin <= 1'b1;
    repeat (3) @(posedge pclk);
    check("role", 32'h1, {31'h0, upstream_port});
    role = 1'b1;
    check_all();
    upstream_port_pin <= 1'b0;
    repeat (3) @(posedge pclk);
    role = 1'b0;
    check_all();
    wrap_up();
  end
endmodule
